/* verilog/pcpt_pkg.sv */
package pcpt_pkg;
   localparam int PCPT_ADDR_W = 8;
   localparam int PCPT_DATA_W = 32;
   localparam int PCPT_NCH = 8;
   localparam int PCPT_NTRIG = 6;
   localparam int PCPT_IRQ_W = 2;

   // Register byte offsets
   localparam logic [7:0] PCPT_OFF_TRIG = 8'h00;
   localparam logic [7:0] PCPT_OFF_POL = 8'h04;
   localparam logic [7:0] PCPT_OFF_MODE = 8'h08;
   localparam logic [7:0] PCPT_OFF_ISTAT = 8'h0c;
   localparam logic [7:0] PCPT_OFF_IMASK = 8'h10;

   // Field positions
   localparam int PCPT_TRIG_FLAG_BIT = 7;
   localparam int PCPT_TRIG_EN_LSB = 0;
   localparam int PCPT_GUARD_BIT = 2;
   localparam int PCPT_IRQ_TRIG_BIT = 0;
   localparam int PCPT_IRQ_FAULT_BIT = 1;

   // Reset values
   localparam logic [7:0] PCPT_POL_RST = 8'h00;
   localparam logic [5:0] PCPT_TRIG_EN_RST = 6'h00;
   localparam logic PCPT_GUARD_RST = 1'b0;
   localparam logic [1:0] PCPT_IRQ_RST = 2'h0;

   typedef enum logic [1:0] {
      PCPT_CLR_IDLE = 2'b01,
      PCPT_CLR_ARMED = 2'b10
   } pcpt_clr_e;
endpackage

/* verilog/pcpt_out_stage.sv */
`timescale 1ns/1ps
module pcpt_out_stage
   import pcpt_pkg::*;
#(
   parameter int N = PCPT_NCH
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [N-1:0] wave_i,
   input wire logic [N-1:0] invert_i,
   input wire logic safe_i,
   output logic [N-1:0] chan_o
);
   logic [N-1:0] next_chan;

   // [R5] [R9] Safe level, inversion
   always_comb begin
      if (safe_i) begin
         next_chan = invert_i;
      end else begin
         next_chan = wave_i ^ invert_i;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         chan_o <= '0;
      end else begin
         chan_o <= next_chan;
      end
   end
endmodule

/* verilog/pcpt_top.sv */
// Behaviour
// [R1] Trigger enables: bit3 ch5, bit2 ch4, bit1 ch3, bit0 ch2; fire on match.
// [R2] Eight invert bits at 7:0, reset zero, upper bits reserved.
// [R3] Invert bit 0 means active high output, 1 means active low.
// [R4] Invert bits written only while write_guard_off is 1.
// [R5] Fault with fault control on drives each output to its invert bit.
// [R6] Channels 6 and 7 never trigger; several channels may trigger.
// [R7] Any trigger sets flag bit 7; cleared by read then write zero.
// [R8] A trigger during the clear sequence restarts it; flag stays set.
// [R9] Active-low channels have their waveform inverted before the pin.
`timescale 1ns/1ps
module pcpt_top
   import pcpt_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [PCPT_ADDR_W-1:0] addr_i,
   input wire logic [PCPT_DATA_W-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [PCPT_DATA_W-1:0] rd_data_o,
   input wire logic [CNT_W-1:0] count_i,
   input wire logic [PCPT_NCH*CNT_W-1:0] match_value_i,
   input wire logic [PCPT_NCH-1:0] wave_i,
   input wire logic fault_ctl_en_i,
   input wire logic fault_det_i,
   output logic [PCPT_NCH-1:0] chan_o,
   output logic trig_o,
   output logic irq_o
);
   logic [5:0] trig_fld;
   logic trig_flag;
   pcpt_clr_e clr_state;
   logic [7:0] pol;
   logic guard_off;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic [PCPT_NCH-1:0] eq_prev;
   logic fault_prev;
   logic [5:0] next_trig_fld;
   logic next_trig_flag;
   pcpt_clr_e next_clr_state;
   logic [7:0] next_pol;
   logic next_guard_off;
   logic [1:0] next_irq_stat;
   logic [1:0] next_irq_mask;
   logic [PCPT_DATA_W-1:0] next_rd_data;
   logic [PCPT_NCH-1:0] eq_now;
   logic [PCPT_NCH-1:0] hit;
   logic [5:0] chan_en;
   logic trig_ev;
   logic safe;
   logic fault_ev;

   // Field bits 5:0 hold ch1,ch0,ch5,ch4,ch3,ch2; return per-channel order
   function automatic logic [5:0] en_by_chan(input logic [5:0] f);
      en_by_chan = {f[3], f[2], f[1], f[0], f[5], f[4]};
   endfunction

   function automatic logic sel(input logic [PCPT_ADDR_W-1:0] a,
                                input logic [7:0] off);
      sel = (a == off);
   endfunction

   always_comb begin
      for (int i = 0; i < PCPT_NCH; i++) begin
         eq_now[i] = (count_i == match_value_i[i*CNT_W +: CNT_W]);
      end
   end

   assign hit = eq_now & ~eq_prev;
   assign chan_en = en_by_chan(trig_fld);
   // [R1] [R6] Enabled match fires; ch6/7 excluded
   assign trig_ev = |(hit[5:0] & chan_en);
   assign safe = fault_ctl_en_i & fault_det_i;
   assign fault_ev = safe & ~fault_prev;

   always_comb begin
      next_trig_fld = trig_fld;
      next_trig_flag = trig_flag;
      next_clr_state = clr_state;
      next_pol = pol;
      next_guard_off = guard_off;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      next_rd_data = '0;
      if (wr_i) begin
         if (sel(addr_i, PCPT_OFF_TRIG)) begin
            next_trig_fld = wr_data_i[PCPT_TRIG_EN_LSB +: 6];
         end else if (sel(addr_i, PCPT_OFF_POL)) begin
            // [R4] Write guard on invert bits
            if (guard_off) begin
               next_pol = wr_data_i[7:0];
            end
         end else if (sel(addr_i, PCPT_OFF_MODE)) begin
            next_guard_off = wr_data_i[PCPT_GUARD_BIT];
         end else if (sel(addr_i, PCPT_OFF_ISTAT)) begin
            next_irq_stat = irq_stat & ~wr_data_i[1:0];
         end else if (sel(addr_i, PCPT_OFF_IMASK)) begin
            next_irq_mask = wr_data_i[1:0];
         end
      end
      if (rd_i) begin
         if (sel(addr_i, PCPT_OFF_TRIG)) begin
            next_rd_data[PCPT_TRIG_EN_LSB +: 6] = trig_fld;
            next_rd_data[PCPT_TRIG_FLAG_BIT] = trig_flag;
         end else if (sel(addr_i, PCPT_OFF_POL)) begin
            next_rd_data[7:0] = pol;
         end else if (sel(addr_i, PCPT_OFF_MODE)) begin
            next_rd_data[PCPT_GUARD_BIT] = guard_off;
         end else if (sel(addr_i, PCPT_OFF_ISTAT)) begin
            next_rd_data[1:0] = irq_stat;
         end else if (sel(addr_i, PCPT_OFF_IMASK)) begin
            next_rd_data[1:0] = irq_mask;
         end
      end
      // [R7] Flag clear sequence: read while set, then write zero
      case (clr_state)
         PCPT_CLR_IDLE: begin
            if (rd_i && sel(addr_i, PCPT_OFF_TRIG) && trig_flag) begin
               next_clr_state = PCPT_CLR_ARMED;
            end
         end
         PCPT_CLR_ARMED: begin
            if (wr_i && sel(addr_i, PCPT_OFF_TRIG) &&
                !wr_data_i[PCPT_TRIG_FLAG_BIT]) begin
               next_trig_flag = 1'b0;
               next_clr_state = PCPT_CLR_IDLE;
            end
         end
         default: begin
            next_clr_state = PCPT_CLR_IDLE;
         end
      endcase
      // [R8] New trigger restarts sequence, set wins
      if (trig_ev) begin
         next_trig_flag = 1'b1;
         next_clr_state = PCPT_CLR_IDLE;
      end
      if (trig_ev) begin
         next_irq_stat[PCPT_IRQ_TRIG_BIT] = 1'b1;
      end
      if (fault_ev) begin
         next_irq_stat[PCPT_IRQ_FAULT_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         trig_fld <= PCPT_TRIG_EN_RST;
         trig_flag <= 1'b0;
         clr_state <= PCPT_CLR_IDLE;
         // [R2] Invert bits reset to zero
         pol <= PCPT_POL_RST;
         guard_off <= PCPT_GUARD_RST;
         irq_stat <= PCPT_IRQ_RST;
         irq_mask <= PCPT_IRQ_RST;
         eq_prev <= '0;
         fault_prev <= 1'b0;
         trig_o <= 1'b0;
         rd_data_o <= '0;
      end else begin
         trig_fld <= next_trig_fld;
         trig_flag <= next_trig_flag;
         clr_state <= next_clr_state;
         pol <= next_pol;
         guard_off <= next_guard_off;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         eq_prev <= eq_now;
         fault_prev <= safe;
         trig_o <= trig_ev;
         rd_data_o <= next_rd_data;
      end
   end

   assign irq_o = |(irq_stat & irq_mask);

   // [R3] [R5] [R9] Polarity and safe level at the pins
   pcpt_out_stage #(
      .N(PCPT_NCH)
   ) u_out (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .wave_i(wave_i),
      .invert_i(pol),
      .safe_i(safe),
      .chan_o(chan_o)
   );

   a_pol_guard: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wr_i && addr_i == PCPT_OFF_POL && !guard_off) |=> $stable(pol))
      else $error("Invert bits changed while guarded"); // [R4]

   a_pol_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wr_i && addr_i == PCPT_OFF_POL && guard_off)
      |=> pol == $past(wr_data_i[7:0]))
      else $error("Invert bits not written"); // [R2]

   a_out_polarity: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !safe |=> chan_o == ($past(wave_i) ^ $past(pol)))
      else $error("Channel output polarity wrong"); // [R3]

   a_out_invert: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!safe && pol[0] && wave_i[0]) |=> !chan_o[0])
      else $error("Active-low channel not inverted"); // [R9]

   a_safe_level: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      safe |=> chan_o == $past(pol))
      else $error("Safe level not driven in fault"); // [R5]

   a_trig_cause: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      trig_o |-> ($past(hit[5:0]) & $past(chan_en)) != 6'h00)
      else $error("Trigger without enabled match"); // [R1]

   a_no_hi_trig: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (hit[7:6] != 2'b00 && (hit[5:0] & chan_en) == 6'h00) |=> !trig_o)
      else $error("Channel 6 or 7 produced a trigger"); // [R6]

   a_flag_set: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      trig_o |-> trig_flag)
      else $error("Trigger flag not set"); // [R7]

   a_clr_restart: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (clr_state == PCPT_CLR_ARMED && trig_ev)
      |=> trig_flag && clr_state == PCPT_CLR_IDLE)
      else $error("Clear sequence not restarted"); // [R8]
endmodule

/* tb/pcpt_pin_model.sv */
`timescale 1ns/1ps
module pcpt_pin_model
   import pcpt_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic trig_i,
   output logic [PCPT_NCH-1:0] wave_o,
   output logic [31:0] trig_count_o
);
   // Waveform changes every cycle while running
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         wave_o <= '0;
         trig_count_o <= '0;
      end else begin
         if (run_i) begin
            wave_o <= wave_o + 8'h35;
         end
         if (trig_i) begin
            trig_count_o <= trig_count_o + 32'h1;
         end
      end
   end
endmodule

/* tb/pwm_channel_polarity_trigger_tb.sv */
`timescale 1ns/1ps
module pwm_channel_polarity_trigger_tb;
   import pcpt_pkg::*;
   logic clk_sys_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, rd_d = 0, run = 0;
   logic fault_ctl_en_i = 0, fault_det_i = 0, trig_o, irq_o;
   logic [7:0] addr_i = '0, pol, wave_i, chan_o;
   logic [31:0] wr_data_i = '0, rd_data_o, exp_q[$];
   logic [15:0] count_i = '0;
   logic [127:0] match_value_i = '1;
   int mismatches = 0, samples_checked = 0, k;
   logic [31:0] ntrig;
   int bitmap[6] = '{4, 5, 0, 1, 2, 3};
   pcpt_top i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
      .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
      .rd_data_o(rd_data_o), .count_i(count_i),
      .match_value_i(match_value_i), .wave_i(wave_i),
      .fault_ctl_en_i(fault_ctl_en_i), .fault_det_i(fault_det_i),
      .chan_o(chan_o), .trig_o(trig_o), .irq_o(irq_o));
   pcpt_pin_model i_pins (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .run_i(run), .trig_i(trig_o), .wave_o(wave_i), .trig_count_o(ntrig));
   always #4 clk_sys_i = ~clk_sys_i;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      cyc(1);
      wr_i <= 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      addr_i <= a;
      rd_i <= 1'b1;
      cyc(1);
      rd_i <= 1'b0;
      cyc(1);
   endtask
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge clk_sys_i) rd_d <= rd_i;
   // Read data compared in the one cycle it stands
   always @(negedge clk_sys_i) begin
      if (rd_d && exp_q.size() > 0) begin
         check(rd_data_o, exp_q.pop_front());
      end
   end
   initial begin
      #300000;
      mismatches++;
      summarize();
   end
   initial begin
      k = $urandom(32'h9b9c0742);
      cyc(20);
      rst_i <= 1'b0;
      cyc(1);
      rd(PCPT_OFF_POL, 32'h0);
      rd(8'h14, 32'h0);
      wr(PCPT_OFF_POL, 32'hff);
      rd(PCPT_OFF_POL, 32'h0);
      wr(PCPT_OFF_MODE, 32'h4);
      rd(PCPT_OFF_MODE, 32'h4);
      pol = 8'($urandom);
      wr(PCPT_OFF_POL, {24'hffffff, pol});
      wr(PCPT_OFF_MODE, 32'h0);
      wr(PCPT_OFF_POL, 32'h0);
      rd(PCPT_OFF_POL, {24'h0, pol});
      run <= 1'b1;
      fault_det_i <= 1'b1;
      cyc(5);
      run <= 1'b0;
      cyc(2);
      @(negedge clk_sys_i);
      check(chan_o, wave_i ^ pol);
      @(posedge clk_sys_i);
      fault_ctl_en_i <= 1'b1;
      cyc(2);
      @(negedge clk_sys_i);
      check(chan_o, pol);
      @(posedge clk_sys_i);
      fault_ctl_en_i <= 1'b0;
      for (int ch = 0; ch < 8; ch++) begin
         wr(PCPT_OFF_TRIG, (ch < 6) ? (32'h1 << bitmap[ch]) : 32'h3f);
         match_value_i <= ~(128'hfffa << (ch * 16));
         count_i <= 16'h5;
         cyc(1);
         @(negedge clk_sys_i);
         check(trig_o, ch < 6);
         @(negedge clk_sys_i);
         check(trig_o, 1'b0);
         @(posedge clk_sys_i);
         count_i <= 16'h0;
         cyc(1);
      end
      check(ntrig, 32'h6);
      rd(PCPT_OFF_TRIG, 32'hbf);
      wr(PCPT_OFF_TRIG, 32'hbf);
      rd(PCPT_OFF_TRIG, 32'hbf);
      match_value_i <= ~128'hfffa;
      count_i <= 16'h5;
      cyc(2);
      count_i <= 16'h0;
      wr(PCPT_OFF_TRIG, 32'h3f);
      rd(PCPT_OFF_TRIG, 32'hbf);
      wr(PCPT_OFF_TRIG, 32'h3f);
      rd(PCPT_OFF_TRIG, 32'h3f);
      wr(PCPT_OFF_IMASK, 32'h0);
      @(negedge clk_sys_i);
      check(irq_o, 1'b0);
      @(posedge clk_sys_i);
      wr(PCPT_OFF_IMASK, 32'h1);
      rd(PCPT_OFF_IMASK, 32'h1);
      @(negedge clk_sys_i);
      check(irq_o, 1'b1);
      @(posedge clk_sys_i);
      rd(PCPT_OFF_ISTAT, 32'h3);
      wr(PCPT_OFF_ISTAT, 32'h1);
      rd(PCPT_OFF_ISTAT, 32'h2);
      @(negedge clk_sys_i);
      check(irq_o, 1'b0);
      @(posedge clk_sys_i);
      // Fault entry bit through its own mask
      wr(PCPT_OFF_IMASK, 32'h2);
      rd(PCPT_OFF_IMASK, 32'h2);
      @(negedge clk_sys_i);
      check(irq_o, 1'b1);
      @(posedge clk_sys_i);
      wr(PCPT_OFF_ISTAT, 32'h2);
      @(negedge clk_sys_i);
      check(irq_o, 1'b0);
      @(posedge clk_sys_i);
      // Second reset in mid-run
      rst_i <= 1'b1;
      cyc(2);
      rst_i <= 1'b0;
      cyc(1);
      rd(PCPT_OFF_POL, 32'h0);
      rd(PCPT_OFF_TRIG, 32'h0);
      rd(PCPT_OFF_MODE, 32'h0);
      @(negedge clk_sys_i);
      check(chan_o, wave_i);
      for (k = 0; k < 10 && exp_q.size() > 0; k++) begin
         cyc(1);
      end
      if (exp_q.size() > 0) begin
         mismatches++;
      end
      summarize();
   end
endmodule
